// ### rtl/binary_arith_flag_unit.sv
// Purpose: Binary add, subtract, multiply, divide and double add with flags
// Assumes: APB slave, one wait state per access, 10 MHz pclk
// Notes: A command write executes in the same edge it is accepted
//
// Functional notes
// - Execution condition low: no operation, results and flags unchanged.
// - Subtract computes minuend minus subtrahend minus carry, low 16 bits.
// - Negative difference sets carry; result holds two's complement.
// - 16-bit add/subtract: overflow above 7FFF, underflow below 8000.
// - Zero flag set when result zero, else cleared, all five operations except divide by zero.
// - Negative flag copies bit 15 of the operation's chosen result word.
// - Multiply: unsigned product, low word to result, high to next.
// - Multiply and divide treat operands as unsigned only.
// - Divide: quotient to result word, remainder to next word.
// - Divide by zero divisor raises the error flag.
// - Nonexistent indirect operand raises the error flag.
// - Double add: two 32-bit pairs plus carry into a word pair.
// - Double add sets carry when the sum exceeds FFFF FFFF.
// - Double add: overflow above 7FFF FFFF, underflow below 8000 0000.
// - Carry flag holds the digit beyond the 32-bit double add sum.
// - Add/subtract always update carry, overflow and underflow together.
// - 16-bit add sums augend, addend, carry; carry above FFFF.
`default_nettype none

module binary_arith_flag_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [arith_pkg::ADDR_W-1:0] paddr,
  input wire logic [arith_pkg::DATA_W-1:0] pwdata,
  output logic [arith_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);

  import arith_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [WORD_W-1:0] augend_word_reg;
  logic [WORD_W-1:0] addend_word_reg;
  logic [WORD_W-1:0] augend_hi_reg;
  logic [WORD_W-1:0] addend_hi_reg;
  flags_s flags_reg;
  flags_s flags_next;
  word_pair_s result_reg;
  word_pair_s result_next;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire access_phase = psel & penable;
  wire wr_en = access_phase & pwrite & pready_reg;
  wire rd_en = access_phase & ~pwrite & pready_reg;
  wire sel_opa_lo = (paddr == OFF_OPA_LO);
  wire sel_opb_lo = (paddr == OFF_OPB_LO);
  wire sel_opa_hi = (paddr == OFF_OPA_HI);
  wire sel_opb_hi = (paddr == OFF_OPB_HI);
  wire sel_cmd = (paddr == OFF_CMD);
  wire sel_flags = (paddr == OFF_FLAGS);
  wire sel_res_lo = (paddr == OFF_RES_LO);
  wire sel_res_hi = (paddr == OFF_RES_HI);
  wire sel_irq_status = (paddr == OFF_IRQ_STATUS);
  wire sel_irq_mask = (paddr == OFF_IRQ_MASK);
  wire sel_any = sel_opa_lo | sel_opb_lo | sel_opa_hi | sel_opb_hi |
                 sel_cmd | sel_flags | sel_res_lo | sel_res_hi |
                 sel_irq_status | sel_irq_mask;
  wire read_only_hit = sel_res_lo | sel_res_hi | sel_irq_status;
  wire bad_access = ~sel_any | (pwrite & read_only_hit);

  // ------------------------------------------------------------
  // Command fields
  // ------------------------------------------------------------
  wire [OP_W-1:0] cmd_code = pwdata[CMD_OP_LSB +: OP_W];
  wire cmd_exec = pwdata[CMD_EXEC_BIT];
  wire cmd_fault = pwdata[CMD_FAULT_BIT];
  wire cmd_write = wr_en & sel_cmd;
  wire do_cmd = cmd_write & cmd_exec;
  wire cin = flags_reg.carry_flag;

  // ------------------------------------------------------------
  // 16-bit add and subtract
  // ------------------------------------------------------------
  wire [16:0] add16 = {1'b0, augend_word_reg} + {1'b0, addend_word_reg} +
                      {16'h0000, cin};
  wire [16:0] sub16 = {1'b0, augend_word_reg} - {1'b0, addend_word_reg} -
                      {16'h0000, cin};
  wire signed [17:0] a16_s = $signed({{2{augend_word_reg[15]}},
                                      augend_word_reg});
  wire signed [17:0] b16_s = $signed({{2{addend_word_reg[15]}},
                                      addend_word_reg});
  wire signed [17:0] cin16_s = $signed({17'h00000, cin});
  wire signed [17:0] sadd16 = a16_s + b16_s + cin16_s;
  wire signed [17:0] ssub16 = a16_s - b16_s - cin16_s;

  // ------------------------------------------------------------
  // 16-bit result fields
  // ------------------------------------------------------------
  wire [WORD_W-1:0] add16_word = add16[WORD_W-1:0];
  wire [WORD_W-1:0] sub16_word = sub16[WORD_W-1:0];
  wire add16_carry = add16[WORD_W];
  wire sub16_borrow = sub16[WORD_W];
  wire add16_over = (sadd16 > S16_MAX);
  wire add16_under = (sadd16 < S16_MIN);
  wire sub16_over = (ssub16 > S16_MAX);
  wire sub16_under = (ssub16 < S16_MIN);

  // ------------------------------------------------------------
  // 32-bit add
  // ------------------------------------------------------------
  wire [31:0] a32 = {augend_hi_reg, augend_word_reg};
  wire [31:0] b32 = {addend_hi_reg, addend_word_reg};
  wire [32:0] add32 = {1'b0, a32} + {1'b0, b32} +
                      {32'h0000_0000, cin};
  wire signed [33:0] sadd32 = $signed({{2{a32[31]}}, a32}) +
                              $signed({{2{b32[31]}}, b32}) +
                              $signed({33'h0_0000_0000, cin});
  wire [DATA_W-1:0] add32_sum = add32[DATA_W-1:0];
  wire add32_carry = add32[DATA_W];
  wire add32_over = (sadd32 > S32_MAX);
  wire add32_under = (sadd32 < S32_MIN);
  wire add32_zero = (add32_sum == DATA_ZERO);

  // ------------------------------------------------------------
  // Unsigned multiply and divide
  // ------------------------------------------------------------
  wire [31:0] product = {WORD_ZERO, augend_word_reg} *
                        {WORD_ZERO, addend_word_reg};
  wire div_zero = (addend_word_reg == WORD_ZERO);
  wire [WORD_W-1:0] safe_div = div_zero ? 16'h0001 : addend_word_reg;
  wire [WORD_W-1:0] quotient = augend_word_reg / safe_div;
  wire [WORD_W-1:0] remainder = augend_word_reg % safe_div;

  // ------------------------------------------------------------
  // Product and quotient fields
  // ------------------------------------------------------------
  wire [WORD_W-1:0] prod_lo = product[WORD_W-1:0];
  wire [WORD_W-1:0] prod_hi = product[DATA_W-1:WORD_W];
  wire prod_zero = (product == DATA_ZERO);
  wire quot_zero = (quotient == WORD_ZERO);

  // ------------------------------------------------------------
  // Operation result and flag selection
  // ------------------------------------------------------------
  always_comb begin
    result_next = result_reg;
    flags_next = flags_reg;
    if (cmd_fault) begin
      flags_next.error_flag = 1'b1;
    end else begin
      flags_next.error_flag = 1'b0;
      unique case (cmd_code)
        binary_add: begin
          result_next.lo = add16_word;
          flags_next.carry_flag = add16_carry;
          flags_next.overflow_flag = add16_over;
          flags_next.underflow_flag = add16_under;
          flags_next.zero_flag = (add16_word == WORD_ZERO);
          flags_next.negative_flag = add16_word[WORD_W-1];
        end
        binary_subtract: begin
          result_next.lo = sub16_word;
          flags_next.carry_flag = sub16_borrow;
          flags_next.overflow_flag = sub16_over;
          flags_next.underflow_flag = sub16_under;
          flags_next.zero_flag = (sub16_word == WORD_ZERO);
          flags_next.negative_flag = sub16_word[WORD_W-1];
        end
        binary_multiply: begin
          result_next.lo = prod_lo;
          result_next.hi = prod_hi;
          flags_next.zero_flag = prod_zero;
          flags_next.negative_flag = prod_hi[WORD_W-1];
        end
        binary_divide: begin
          if (div_zero) begin
            flags_next.error_flag = 1'b1;
          end else begin
            result_next.lo = quotient;
            result_next.hi = remainder;
            flags_next.zero_flag = quot_zero;
            flags_next.negative_flag = quotient[WORD_W-1];
          end
        end
        double_binary_add: begin
          result_next.lo = add32_sum[WORD_W-1:0];
          result_next.hi = add32_sum[DATA_W-1:WORD_W];
          flags_next.carry_flag = add32_carry;
          flags_next.overflow_flag = add32_over;
          flags_next.underflow_flag = add32_under;
          flags_next.zero_flag = add32_zero;
          flags_next.negative_flag = add32_sum[WORD_W-1];
        end
        default: begin
          flags_next.error_flag = 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Operand registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      augend_word_reg <= WORD_ZERO;
    end else if (wr_en && sel_opa_lo) begin
      augend_word_reg <= pwdata[WORD_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addend_word_reg <= WORD_ZERO;
    end else if (wr_en && sel_opb_lo) begin
      addend_word_reg <= pwdata[WORD_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      augend_hi_reg <= WORD_ZERO;
    end else if (wr_en && sel_opa_hi) begin
      augend_hi_reg <= pwdata[WORD_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addend_hi_reg <= WORD_ZERO;
    end else if (wr_en && sel_opb_hi) begin
      addend_hi_reg <= pwdata[WORD_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Results and flags, updated together by a command; flags also by a flags write
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= PAIR_RESET;
    end else if (do_cmd) begin
      result_reg <= result_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= FLAGS_RESET;
    end else if (do_cmd) begin
      flags_reg <= flags_next;
    end else if (wr_en && sel_flags) begin
      flags_reg <= flags_s'(pwdata[FLAGS_W-1:0]);
    end
  end

  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  wire [IRQ_W-1:0] irq_events = {do_cmd & flags_next.error_flag, do_cmd};
  wire irq_status_read = rd_en & sel_irq_status;
  wire irq_mask_write = wr_en & sel_irq_mask;
  wire [IRQ_W-1:0] irq_mask_next = irq_mask_write ? pwdata[IRQ_W-1:0] :
                                   irq_mask_reg;

  always_comb begin
    irq_status_next = irq_status_reg;
    if (irq_status_read) begin
      irq_status_next = '0;
    end
    irq_status_next = irq_status_next | irq_events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= '0;
    end else begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_next & irq_mask_next);
    end
  end

  // ------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------
  wire [DATA_W-1:0] rd_opa_lo = {WORD_ZERO, augend_word_reg};
  wire [DATA_W-1:0] rd_opb_lo = {WORD_ZERO, addend_word_reg};
  wire [DATA_W-1:0] rd_opa_hi = {WORD_ZERO, augend_hi_reg};
  wire [DATA_W-1:0] rd_opb_hi = {WORD_ZERO, addend_hi_reg};
  wire [DATA_W-1:0] rd_flags = {26'h000_0000, flags_reg};
  wire [DATA_W-1:0] rd_res_lo = {WORD_ZERO, result_reg.lo};
  wire [DATA_W-1:0] rd_res_hi = {WORD_ZERO, result_reg.hi};
  wire [DATA_W-1:0] rd_irq_st = {30'h0000_0000, irq_status_reg};
  wire [DATA_W-1:0] rd_irq_mk = {30'h0000_0000, irq_mask_reg};
  wire [DATA_W-1:0] rd_mux =
    sel_opa_lo ? rd_opa_lo :
    sel_opb_lo ? rd_opb_lo :
    sel_opa_hi ? rd_opa_hi :
    sel_opb_hi ? rd_opb_hi :
    sel_flags ? rd_flags :
    sel_res_lo ? rd_res_lo :
    sel_res_hi ? rd_res_hi :
    sel_irq_status ? rd_irq_st :
    sel_irq_mask ? rd_irq_mk :
    DATA_ZERO;

  // ------------------------------------------------------------
  // Bus answer, one wait state
  // ------------------------------------------------------------
  wire answer_now = access_phase & ~pready_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= answer_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= answer_now & bad_access;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= DATA_ZERO;
    end else if (answer_now && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

endmodule : binary_arith_flag_unit

`default_nettype wire

// ### rtl/arith_pkg.sv
// Purpose: Shared constants and types of the binary arithmetic flag unit
// Assumes: APB register map with 32-bit data, one word per register
// Notes: Flag layout is shared by the flag register and the bench model
`default_nettype none

package arith_pkg;

  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_OPA_LO = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_OPB_LO = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_OPA_HI = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_OPB_HI = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_CMD = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_RES_LO = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_RES_HI = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h024;

  // ------------------------------------------------------------
  // Command fields
  // ------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int OP_W = 3;
  localparam int CMD_EXEC_BIT = 3;
  localparam int CMD_FAULT_BIT = 4;

  // ------------------------------------------------------------
  // Interrupt fields
  // ------------------------------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;

  // ------------------------------------------------------------
  // Special status word bit addresses
  // ------------------------------------------------------------
  localparam int STATUS_OVERFLOW_ADDR = 25404;
  localparam int STATUS_UNDERFLOW_ADDR = 25405;
  localparam int STATUS_CARRY_ADDR = 25504;

  // ------------------------------------------------------------
  // Signed range limits
  // ------------------------------------------------------------
  localparam logic signed [17:0] S16_MAX = 18'sh07FFF;
  localparam logic signed [17:0] S16_MIN = 18'sh38000;
  localparam logic signed [33:0] S32_MAX = 34'sh07FFFFFFF;
  localparam logic signed [33:0] S32_MIN = 34'sh380000000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    binary_add,
    binary_subtract,
    binary_multiply,
    binary_divide,
    double_binary_add
  } op_e;

  typedef struct packed {
    logic error_flag;
    logic negative_flag;
    logic zero_flag;
    logic underflow_flag;
    logic overflow_flag;
    logic carry_flag;
  } flags_s;

  localparam int FLAGS_W = 6;
  localparam flags_s FLAGS_RESET = 6'h00;

  typedef struct packed {
    logic [WORD_W-1:0] hi;
    logic [WORD_W-1:0] lo;
  } word_pair_s;

  localparam word_pair_s PAIR_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

endpackage : arith_pkg

`default_nettype wire

// ### verification/arith_port_checker_sva.sv
// Purpose: Port checks for the binary arithmetic flag unit
// Assumes: One wait state APB slave, registered interrupt output
// Notes: Bound to every instance of the unit
`default_nettype none

module arith_port_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [arith_pkg::ADDR_W-1:0] paddr,
  input wire logic [arith_pkg::DATA_W-1:0] pwdata,
  input wire logic [arith_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  import arith_pkg::*;

  // ------------------------------------------------------------
  // Decode and mask mirror
  // ------------------------------------------------------------
  logic [IRQ_W-1:0] mask_reg;
  wire logic take = psel && penable && pready;
  wire logic mapped = paddr <= OFF_IRQ_MASK && paddr[1:0] == 2'h0;
  wire logic ro_addr = paddr == OFF_RES_LO || paddr == OFF_RES_HI ||
                       paddr == OFF_IRQ_STATUS;
  wire logic cmd_go = take && pwrite && paddr == OFF_CMD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= '0;
    end else if (take && pwrite && paddr == OFF_IRQ_MASK) begin
      mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence

  a_ready_wait: assert property (s_setup |=> s_wait)
    else $error("ready not after one wait state");
  a_ready_alone: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (take && !mapped |->
    pslverr && (pwrite || prdata == DATA_ZERO))
    else $error("unmapped access not refused");
  a_ro_write: assert property (take && pwrite && ro_addr |-> pslverr)
    else $error("read only write not refused");
  a_mapped_ok: assert property (take && mapped && !(pwrite && ro_addr)
    |-> !pslverr)
    else $error("legal access refused");
  a_upper_zero: assert property (take && !pwrite && paddr <= OFF_RES_HI
    |-> prdata[31:16] == 16'h0000)
    else $error("upper half of word not zero");
  a_irq_event: assert property (cmd_go && pwdata[CMD_EXEC_BIT] &&
    mask_reg[IRQ_DONE_BIT] |-> ##[1:2] irq)
    else $error("done event gave no interrupt");
  a_irq_idle: assert property (cmd_go && !pwdata[CMD_EXEC_BIT]
    |=> $stable(irq) [*2])
    else $error("idle command moved interrupt");
  a_irq_masked: assert property (mask_reg == 2'h0 ##1 mask_reg == 2'h0
    |-> !irq)
    else $error("interrupt while fully masked");

endmodule : arith_port_checker

bind binary_arith_flag_unit arith_port_checker u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));

`default_nettype wire

// ### verification/binary_arith_flag_unit_test.sv
// Purpose: Self-checking bench of the binary arithmetic flag unit
// Assumes: APB master with one idle cycle between transfers
// Notes: Fixed seed, corner table then random commands
`default_nettype none

module binary_arith_flag_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  import arith_pkg::*;

  // ------------------------------------------------------------
  // Signals and model state
  // ------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic serr;
  int failures = 0;
  int total_checks = 0;
  int seed = 32'h2A95;
  flags_s m_fl;
  word_pair_s m_res;
  logic [IRQ_W-1:0] m_st, m_mask;

  binary_arith_flag_unit u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      finish_test();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input logic e);
    apb(1'b1, a, d);
    check("write error", {31'h0, serr}, {31'h0, e});
  endtask : wr

  task automatic rdchk(input string what, input logic [ADDR_W-1:0] a,
      input logic [31:0] x);
    apb(1'b0, a, DATA_ZERO);
    check(what, rd, x);
  endtask : rdchk

  function automatic void model(input logic [4:0] cmd,
      input logic [15:0] a, input logic [15:0] b, input logic [15:0] ah,
      input logic [15:0] bh);
    logic [33:0] s;
    logic signed [33:0] v;
    logic c;
    logic wide;
    c = m_fl.carry_flag;
    wide = cmd[2:0] == 3'h2 || cmd[2:0] == 3'h4;
    if (!cmd[CMD_EXEC_BIT]) begin
      return;
    end
    m_st[IRQ_DONE_BIT] = 1'b1;
    if (cmd[CMD_FAULT_BIT] || cmd[2:0] > 3'h4 ||
        (cmd[2:0] == 3'h3 && b == 16'h0000)) begin
      m_fl.error_flag = 1'b1;
      m_st[IRQ_ERR_BIT] = 1'b1;
      return;
    end
    m_fl.error_flag = 1'b0;
    case (cmd[2:0])
      3'h0, 3'h1: begin
        s = cmd[0] ? {18'h0, a} - b - c : {18'h0, a} + b + c;
        v = cmd[0] ? $signed(a) - $signed(b) - $signed({1'b0, c})
                   : $signed(a) + $signed(b) + $signed({1'b0, c});
        m_res.lo = s[15:0];
        m_fl.carry_flag = cmd[0] ? s[33] : s[16];
        m_fl.overflow_flag = v > S16_MAX;
        m_fl.underflow_flag = v < S16_MIN;
      end
      3'h2: begin
        s = a * b;
        m_res = s[31:0];
      end
      3'h3: m_res = {a % b, a / b};
      default: begin
        s = {2'h0, ah, a} + {bh, b} + c;
        v = $signed({ah, a}) + $signed({bh, b}) + $signed({1'b0, c});
        m_res = s[31:0];
        m_fl.carry_flag = s[32];
        m_fl.overflow_flag = v > S32_MAX;
        m_fl.underflow_flag = v < S32_MIN;
      end
    endcase
    m_fl.zero_flag = wide ? m_res == 32'h0 : m_res.lo == 16'h0;
    m_fl.negative_flag = cmd[2:0] == 3'h2 ? m_res.hi[15] : m_res.lo[15];
  endfunction : model

  task automatic run_op(input logic [4:0] cmd, input logic [15:0] a,
      input logic [15:0] b, input logic [15:0] ah, input logic [15:0] bh,
      input logic [5:0] fl, input logic [1:0] mk);
    wr(OFF_OPA_LO, {16'h0, a}, 1'b0);
    wr(OFF_OPB_LO, {16'h0, b}, 1'b0);
    wr(OFF_OPA_HI, {16'h0, ah}, 1'b0);
    wr(OFF_OPB_HI, {16'h0, bh}, 1'b0);
    wr(OFF_FLAGS, {26'h0, fl}, 1'b0);
    wr(OFF_IRQ_MASK, {30'h0, mk}, 1'b0);
    m_fl = fl;
    m_mask = mk;
    model(cmd, a, b, ah, bh);
    wr(OFF_CMD, {27'h0, cmd}, 1'b0);
    rdchk("flags", OFF_FLAGS, {26'h0, m_fl});
    rdchk("result low", OFF_RES_LO, {16'h0, m_res.lo});
    rdchk("result high", OFF_RES_HI, {16'h0, m_res.hi});
    check("irq", {31'h0, irq}, {31'h0, |(m_st & m_mask)});
    rdchk("irq status", OFF_IRQ_STATUS, {30'h0, m_st});
    m_st = '0;
  endtask : run_op

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r, x, y;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    m_fl = FLAGS_RESET;
    m_res = PAIR_RESET;
    m_st = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rdchk("reset value", ADDR_W'(4 * i), DATA_ZERO);
    end
    $display("reset test done");
    apb(1'b0, 12'h028, DATA_ZERO);
    check("unmapped data", rd, DATA_ZERO);
    check("unmapped error", {31'h0, serr}, 32'h1);
    wr(OFF_RES_LO, 32'h0000_1234, 1'b1);
    wr(OFF_IRQ_STATUS, 32'h0000_0003, 1'b1);
    rdchk("result low", OFF_RES_LO, DATA_ZERO);
    wr(OFF_OPA_LO, 32'hFFFF_ABCD, 1'b0);
    rdchk("operand", OFF_OPA_LO, 32'h0000_ABCD);
    $display("access test done");
    run_op(5'h08, 16'h7FFF, 16'h0001, 16'h0, 16'h0, 6'h00, 2'h3);
    run_op(5'h08, 16'h8000, 16'hFFFF, 16'h0, 16'h0, 6'h00, 2'h1);
    run_op(5'h08, 16'hFFFF, 16'h0000, 16'h0, 16'h0, 6'h01, 2'h0);
    run_op(5'h09, 16'h7544, 16'hC47A, 16'h0, 16'h0, 6'h00, 2'h3);
    run_op(5'h09, 16'h8AD0, 16'h0BB8, 16'h0, 16'h0, 6'h00, 2'h3);
    run_op(5'h09, 16'h0000, 16'h0000, 16'h0, 16'h0, 6'h01, 2'h3);
    run_op(5'h09, 16'h1234, 16'h1233, 16'h0, 16'h0, 6'h01, 2'h2);
    run_op(5'h0A, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0, 6'h07, 2'h3);
    run_op(5'h0A, 16'h0000, 16'h1234, 16'h0, 16'h0, 6'h00, 2'h3);
    run_op(5'h0B, 16'hFFFF, 16'h0003, 16'h0, 16'h0, 6'h00, 2'h3);
    run_op(5'h0B, 16'h1234, 16'h0000, 16'h0, 16'h0, 6'h00, 2'h2);
    run_op(5'h0B, 16'h0005, 16'h0007, 16'h0, 16'h0, 6'h00, 2'h3);
    run_op(5'h0C, 16'hFFFF, 16'h0, 16'hFFFF, 16'h0, 6'h01, 2'h3);
    run_op(5'h0C, 16'hFFFF, 16'h1, 16'h7FFF, 16'h0, 6'h00, 2'h3);
    run_op(5'h0C, 16'h0, 16'h0, 16'h8000, 16'hFFFF, 6'h00, 2'h3);
    run_op(5'h18, 16'h0001, 16'h0001, 16'h0, 16'h0, 6'h00, 2'h2);
    for (int i = 0; i < 8; i++) begin
      run_op(5'(i), 16'h800, 16'h8000, 16'h0, 16'h0, 6'h3F, 2'h3);
      run_op(5'(8 + i), 16'h6B3C, 16'hEF25, 16'h1, 16'h2, 6'h00, 2'h3);
    end
    $display("corner test done");
    for (int i = 0; i < 48; i++) begin
      r = $random(seed);
      x = $random(seed);
      y = $random(seed);
      run_op({r[4] & r[5] & r[7], r[6:5] != 2'h0, r[2:0]}, x[15:0],
             x[31:16], y[15:0], y[31:16], r[13:8], r[15:14]);
    end
    $display("random test done");
    finish_test();
  end

endmodule : binary_arith_flag_unit_test

`default_nettype wire
